// file: nvw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Program start ignored without unlock set
// - Program cycle timed by asynchronous timer
// - Program start self-clears at completion
// - Program unlock cleared at power-on
// - Bank bytes reset to zero
// - Completion sets done and shared flags
// - Vector needs all enables, stack not full
// - Service clears shared flag only
// - Unlock bit 3, start bit 2
// - Fetch unlock bit 1, start bit 0
// - 64 bytes, 6-bit index
// - Fetch needs unlock, self-clears, byte held
// - Fetch start ignored without fetch unlock
module nvw_ctrl #(
  parameter int PROG_TICKS = nvw_pkg::NVW_PROG_TICKS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic timer_toggle,
  input wire logic idx_we,
  input wire logic [nvw_pkg::NVW_IDX_W-1:0] idx_wdata,
  input wire logic buf_we,
  input wire logic [nvw_pkg::NVW_DATA_W-1:0] buf_wdata,
  input wire logic bank1_we,
  input wire logic bank2_we,
  input wire logic [7:0] bank_wdata,
  input wire logic offset1_we,
  input wire logic [7:0] offset1_wdata,
  input wire logic ind_we,
  input wire logic [7:0] ind_wdata,
  input wire logic global_irq_enable,
  input wire logic nv_done_irq_enable,
  input wire logic mf_irq_enable,
  input wire logic stack_full,
  input wire logic irq_service,
  input wire logic done_flag_clr,
  input wire logic low_power,
  output logic [7:0] nv_cell_index,
  output logic [7:0] nv_byte_buffer,
  output logic [7:0] nv_control_reg,
  output logic [7:0] indirect_port1,
  output logic [7:0] pointer1_bank_byte,
  output logic [7:0] pointer2_bank_byte,
  output logic [7:0] pointer1_offset_byte,
  output logic nv_done_irq_flag,
  output logic mf_irq_flag,
  output logic irq_vector,
  output logic op_failed
);
  import nvw_pkg::*;

  logic [NVW_DATA_W-1:0] mem_r [NVW_DEPTH];
  logic [NVW_DATA_W-1:0] mem_nxt [NVW_DEPTH];
  nvw_state_e state_r, state_nxt;
  logic [NVW_IDX_W-1:0] idx_r, idx_nxt, lat_idx_r, lat_idx_nxt;
  logic [7:0] buf_r, buf_nxt, lat_data_r, lat_data_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [7:0] bank1_r, bank1_nxt, bank2_r, bank2_nxt, off1_r, off1_nxt;
  logic [7:0] ticks_r, ticks_nxt;
  logic done_r, done_nxt, mf_r, mf_nxt, vec_r, vec_nxt, fail_r, fail_nxt;
  logic tick;
  logic ctrl_sel;
  logic prog_end;
  logic [7:0] ind_r, ind_nxt;

  nvw_tick_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(timer_toggle),
    .tick_pulse(tick)
  );

  // Control register writable only through the indirect port at bank 1
  assign ctrl_sel = (bank1_r == NVW_CTRL_BANK) && (off1_r == NVW_CTRL_OFFSET);
  assign prog_end = (state_r == NVW_PROG) && tick &&
                    (ticks_r == 8'(PROG_TICKS - 1));

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    buf_nxt = buf_r;
    ctrl_nxt = ctrl_r;
    bank1_nxt = bank1_r;
    bank2_nxt = bank2_r;
    off1_nxt = off1_r;
    lat_idx_nxt = lat_idx_r;
    lat_data_nxt = lat_data_r;
    ticks_nxt = ticks_r;
    done_nxt = done_r;
    mf_nxt = mf_r;
    fail_nxt = 1'b0;
    mem_nxt = mem_r;
    if (idx_we) begin
      idx_nxt = idx_wdata;
    end
    if (buf_we) begin
      buf_nxt = buf_wdata;
    end
    if (bank1_we) begin
      bank1_nxt = bank_wdata;
    end
    if (bank2_we) begin
      bank2_nxt = bank_wdata;
    end
    if (offset1_we) begin
      off1_nxt = offset1_wdata;
    end
    if (ind_we && ctrl_sel) begin
      // Unlock bits follow software; start bits only set while idle and unlocked
      ctrl_nxt[NVW_BIT_PUNLOCK] = ind_wdata[NVW_BIT_PUNLOCK];
      ctrl_nxt[NVW_BIT_FUNLOCK] = ind_wdata[NVW_BIT_FUNLOCK];
      if (state_r == NVW_IDLE) begin
        if (ind_wdata[NVW_BIT_PSTART] && ctrl_r[NVW_BIT_PUNLOCK]) begin
          ctrl_nxt[NVW_BIT_PSTART] = 1'b1;
          lat_idx_nxt = idx_r;
          lat_data_nxt = buf_r;
          ticks_nxt = 8'h00;
          state_nxt = NVW_PROG;
        end else if (ind_wdata[NVW_BIT_FSTART] && ctrl_r[NVW_BIT_FUNLOCK]) begin
          ctrl_nxt[NVW_BIT_FSTART] = 1'b1;
          lat_idx_nxt = idx_r;
          ticks_nxt = 8'h00;
          state_nxt = NVW_FETCH;
        end
      end
    end
    case (state_r)
      NVW_IDLE: begin
      end
      NVW_PROG: begin
        if (tick) begin
          ticks_nxt = ticks_r + 8'h01;
        end
        if (low_power) begin
          ctrl_nxt[NVW_BIT_PSTART] = 1'b0;
          fail_nxt = 1'b1;
          state_nxt = NVW_IDLE;
        end else if (prog_end) begin
          mem_nxt[lat_idx_r] = lat_data_r;
          ctrl_nxt[NVW_BIT_PSTART] = 1'b0;
          state_nxt = NVW_IDLE;
        end
      end
      NVW_FETCH: begin
        ticks_nxt = ticks_r + 8'h01;
        if (low_power) begin
          ctrl_nxt[NVW_BIT_FSTART] = 1'b0;
          fail_nxt = 1'b1;
          state_nxt = NVW_IDLE;
        end else if (ticks_r == 8'(NVW_FETCH_CYC - 1)) begin
          buf_nxt = mem_r[lat_idx_r];
          ctrl_nxt[NVW_BIT_FSTART] = 1'b0;
          state_nxt = NVW_IDLE;
        end
      end
      default: begin
        state_nxt = NVW_IDLE;
      end
    endcase
    // Set wins over clear on both flags
    if (done_flag_clr) begin
      done_nxt = 1'b0;
    end
    if (irq_service) begin
      mf_nxt = 1'b0;
    end
    if (prog_end && !low_power) begin
      done_nxt = 1'b1;
      mf_nxt = 1'b1;
    end
    // Indirect view from next state, so the port leaves a flop
    ind_nxt = ((bank1_nxt == NVW_CTRL_BANK) && (off1_nxt == NVW_CTRL_OFFSET)) ?
              {4'h0, ctrl_nxt} : 8'h00;
  end

  // Vector request when both flags and all enables set, stack has room and no service
  assign vec_nxt = global_irq_enable && nv_done_irq_enable && mf_irq_enable &&
                   !stack_full && mf_r && done_r && !irq_service;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= NVW_IDLE;
      idx_r <= NVW_IDX_RST;
      buf_r <= NVW_BUF_RST;
      ctrl_r <= NVW_CTRL_RST;
      bank1_r <= NVW_BANK_RST;
      bank2_r <= NVW_BANK_RST;
      off1_r <= NVW_BANK_RST;
      lat_idx_r <= NVW_IDX_RST;
      lat_data_r <= NVW_BUF_RST;
      ticks_r <= 8'h00;
      done_r <= 1'b0;
      mf_r <= 1'b0;
      vec_r <= 1'b0;
      fail_r <= 1'b0;
      ind_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      buf_r <= buf_nxt;
      ctrl_r <= ctrl_nxt;
      bank1_r <= bank1_nxt;
      bank2_r <= bank2_nxt;
      off1_r <= off1_nxt;
      lat_idx_r <= lat_idx_nxt;
      lat_data_r <= lat_data_nxt;
      ticks_r <= ticks_nxt;
      done_r <= done_nxt;
      mf_r <= mf_nxt;
      vec_r <= vec_nxt;
      fail_r <= fail_nxt;
      ind_r <= ind_nxt;
    end
  end

  // Array content is not cleared by reset
  always_ff @(posedge sys_clk) begin
    mem_r <= mem_nxt;
  end

  assign nv_cell_index = {2'b00, idx_r};
  assign nv_byte_buffer = buf_r;
  assign nv_control_reg = {4'h0, ctrl_r};
  assign indirect_port1 = ind_r;
  assign pointer1_bank_byte = bank1_r;
  assign pointer2_bank_byte = bank2_r;
  assign pointer1_offset_byte = off1_r;
  assign nv_done_irq_flag = done_r;
  assign mf_irq_flag = mf_r;
  assign irq_vector = vec_r;
  assign op_failed = fail_r;

  property p_start_guard;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_r == NVW_IDLE && !ctrl_r[NVW_BIT_PUNLOCK]) |=> !ctrl_r[NVW_BIT_PSTART];
  endproperty
  a_start_guard: assert property (p_start_guard) else $error("start without unlock");

  property p_fetch_guard;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_r == NVW_IDLE && !ctrl_r[NVW_BIT_FUNLOCK]) |=> !ctrl_r[NVW_BIT_FSTART];
  endproperty
  a_fetch_guard: assert property (p_fetch_guard) else $error("fetch without unlock");

  property p_self_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      (prog_end && !low_power) |=> (!ctrl_r[NVW_BIT_PSTART] && state_r == NVW_IDLE);
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("start bit not cleared");

  property p_flags_set;
    @(posedge sys_clk) disable iff (sys_rst)
      (prog_end && !low_power) |=> (done_r && mf_r);
  endproperty
  a_flags_set: assert property (p_flags_set) else $error("completion flags missing");

  property p_nonzero;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(ctrl_r[NVW_BIT_PSTART]) |-> !prog_end;
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("zero-length program");

  property p_vector;
    @(posedge sys_clk) disable iff (sys_rst)
      irq_vector |-> $past(global_irq_enable) && $past(nv_done_irq_enable) &&
        $past(mf_irq_enable) && !$past(stack_full);
  endproperty
  a_vector: assert property (p_vector) else $error("vector without enables");

  property p_service;
    @(posedge sys_clk) disable iff (sys_rst)
      (irq_service && !prog_end && !done_flag_clr && done_r) |=> (!mf_r && done_r);
  endproperty
  a_service: assert property (p_service) else $error("service cleared wrong flag");

  property p_fetch_len;
    @(posedge sys_clk) disable iff (sys_rst)
      ($rose(ctrl_r[NVW_BIT_FSTART]) && !low_power) |-> ##2 !ctrl_r[NVW_BIT_FSTART];
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch did not end");

  property p_prog_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (prog_end && !low_power) |=> (mem_r[$past(lat_idx_r)] == $past(lat_data_r));
  endproperty
  a_prog_write: assert property (p_prog_write) else $error("program data not stored");

  property p_abort;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_r != NVW_IDLE && low_power) |=> (op_failed && state_r == NVW_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("operation not aborted");

  property p_ind_view;
    @(posedge sys_clk) disable iff (sys_rst)
      indirect_port1 == (ctrl_sel ? {4'h0, ctrl_r} : 8'h00);
  endproperty
  a_ind_view: assert property (p_ind_view) else $error("indirect view wrong");
endmodule : nvw_ctrl
`default_nettype wire

// file: nvw_pkg.sv
package nvw_pkg;
  localparam int NVW_IDX_W = 6;
  localparam int NVW_DATA_W = 8;
  localparam int NVW_DEPTH = 64;
  // Control register bit positions
  localparam int NVW_BIT_PUNLOCK = 3;
  localparam int NVW_BIT_PSTART = 2;
  localparam int NVW_BIT_FUNLOCK = 1;
  localparam int NVW_BIT_FSTART = 0;
  // Bank byte that exposes the control register, and its offset
  localparam logic [7:0] NVW_CTRL_BANK = 8'h01;
  localparam logic [7:0] NVW_CTRL_OFFSET = 8'h40;
  // Reset values
  localparam logic [7:0] NVW_BANK_RST = 8'h00;
  localparam logic [3:0] NVW_CTRL_RST = 4'h0;
  localparam logic [5:0] NVW_IDX_RST = 6'h00;
  localparam logic [7:0] NVW_BUF_RST = 8'h00;
  // Internal timer: ticks per program cycle, timer divider, fetch length
  localparam int NVW_PROG_TICKS = 16;
  localparam int NVW_TICK_DIV = 8;
  localparam int NVW_FETCH_CYC = 2;
  localparam int NVW_SYNC_STAGES = 3;
  typedef enum logic [1:0] {NVW_IDLE, NVW_PROG, NVW_FETCH} nvw_state_e;
endpackage : nvw_pkg

// file: nvw_tick_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Brings the asynchronous timer toggle into sys_clk, one pulse per change
module nvw_tick_sync (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic tick_pulse
);
  import nvw_pkg::*;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic pulse_r;
  logic pulse_nxt;

  always_comb begin
    sync_nxt = {sync_r[1:0], async_in};
    pulse_nxt = sync_r[1] ^ sync_r[2];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_r <= 3'h0;
      pulse_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign tick_pulse = pulse_r;
endmodule : nvw_tick_sync
`default_nettype wire

// file: data_eeprom_write_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_write_controller_tb;
  import nvw_pkg::*;
  localparam int TICKS = 2;
  logic sys_clk, sys_rst, timer_toggle, idx_we, buf_we, bank1_we, bank2_we, offset1_we, ind_we;
  logic [NVW_IDX_W-1:0] idx_wdata;
  logic [NVW_DATA_W-1:0] buf_wdata;
  logic [7:0] bank_wdata, offset1_wdata, ind_wdata;
  logic global_irq_enable, nv_done_irq_enable, mf_irq_enable, stack_full;
  logic irq_service, done_flag_clr, low_power;
  logic [7:0] nv_cell_index, nv_byte_buffer, nv_control_reg, indirect_port1;
  logic [7:0] pointer1_bank_byte, pointer2_bank_byte, pointer1_offset_byte;
  logic nv_done_irq_flag, mf_irq_flag, irq_vector, op_failed, seen;
  int err_total = 0;
  int num_checks = 0;

  nvw_ctrl #(.PROG_TICKS(TICKS)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .timer_toggle(timer_toggle), .idx_we(idx_we), .idx_wdata(idx_wdata), .buf_we(buf_we),
    .buf_wdata(buf_wdata), .bank1_we(bank1_we), .bank2_we(bank2_we), .bank_wdata(bank_wdata),
    .offset1_we(offset1_we), .offset1_wdata(offset1_wdata), .ind_we(ind_we),
    .ind_wdata(ind_wdata), .global_irq_enable(global_irq_enable),
    .nv_done_irq_enable(nv_done_irq_enable), .mf_irq_enable(mf_irq_enable),
    .stack_full(stack_full), .irq_service(irq_service), .done_flag_clr(done_flag_clr),
    .low_power(low_power), .nv_cell_index(nv_cell_index), .nv_byte_buffer(nv_byte_buffer),
    .nv_control_reg(nv_control_reg), .indirect_port1(indirect_port1),
    .pointer1_bank_byte(pointer1_bank_byte), .pointer2_bank_byte(pointer2_bank_byte),
    .pointer1_offset_byte(pointer1_offset_byte), .nv_done_irq_flag(nv_done_irq_flag),
    .mf_irq_flag(mf_irq_flag), .irq_vector(irq_vector), .op_failed(op_failed));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One or two back-to-back writes through the indirect port
  task automatic ind_wr(input logic [7:0] a, input logic [7:0] b, input int n);
    ind_we = 1'b1;
    ind_wdata = a;
    step();
    if (n == 2) begin
      ind_wdata = b;
      step();
    end
    ind_we = 1'b0;
    step();
  endtask : ind_wr

  task automatic ld(input logic [5:0] i, input logic [7:0] d);
    idx_we = 1'b1;
    buf_we = 1'b1;
    idx_wdata = i;
    buf_wdata = d;
    step();
    idx_we = 1'b0;
    buf_we = 1'b0;
    step();
  endtask : ld

  task automatic ticks(input int n);
    for (int k = 0; k < n; k++) begin
      timer_toggle = ~timer_toggle;
      repeat (5) step();
    end
  endtask : ticks

  // Bounded poll until a control bit falls
  task automatic wait_low(input int b);
    for (int k = 0; k < 50 && nv_control_reg[b] !== 1'b0; k++) step();
  endtask : wait_low

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    {timer_toggle, idx_we, buf_we, bank1_we, bank2_we, offset1_we, ind_we} = '0;
    {idx_wdata, buf_wdata, bank_wdata, offset1_wdata, ind_wdata} = '0;
    {irq_service, done_flag_clr, low_power} = '0;
    {global_irq_enable, nv_done_irq_enable, mf_irq_enable, stack_full} = 4'hF;
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    chk("ctrl", nv_control_reg, 8'h00);
    chk("bank1", pointer1_bank_byte, 8'h00);
    chk("bank2", pointer2_bank_byte, 8'h00);
    chk("flags", {mf_irq_flag, nv_done_irq_flag}, 8'h00);
    ind_wr(8'h08, 8'h00, 1);
    chk("ctrl_bank0", nv_control_reg, 8'h00);
    bank2_we = 1'b1;
    bank1_we = 1'b1;
    offset1_we = 1'b1;
    bank_wdata = NVW_CTRL_BANK;
    offset1_wdata = NVW_CTRL_OFFSET;
    step();
    {bank1_we, bank2_we, offset1_we} = '0;
    step();
    chk("bank1_wr", pointer1_bank_byte, 8'h01);
    chk("bank2_wr", pointer2_bank_byte, 8'h01);
    chk("offset1", pointer1_offset_byte, 8'h40);
    $display("test reset done");
    ind_wr(8'h04, 8'h00, 1);
    chk("pstart_locked", nv_control_reg, 8'h00);
    ind_wr(8'h01, 8'h00, 1);
    chk("fstart_locked", nv_control_reg, 8'h00);
    $display("test refuse done");
    ld(6'h2A, 8'hA5);
    global_irq_enable = 1'b0;
    ind_wr(8'h08, 8'h0C, 2);
    global_irq_enable = 1'b1;
    chk("ctrl_busy", nv_control_reg, 8'h0C);
    chk("ind_view", indirect_port1, 8'h0C);
    chk("index", nv_cell_index, 8'h2A);
    ld(6'h15, 8'h3C);
    repeat (10) step();
    chk("no_ticks", nv_control_reg, 8'h0C);
    ticks(TICKS - 1);
    chk("one_short", nv_control_reg, 8'h0C);
    ticks(1);
    wait_low(NVW_BIT_PSTART);
    chk("pstart_clr", nv_control_reg, 8'h08);
    chk("done_mf", {mf_irq_flag, nv_done_irq_flag}, 8'h03);
    chk("vec_stack", {7'h0, irq_vector}, 8'h00);
    stack_full = 1'b0;
    repeat (2) step();
    chk("vec_on", {7'h0, irq_vector}, 8'h01);
    nv_done_irq_enable = 1'b0;
    repeat (2) step();
    chk("vec_masked", {7'h0, irq_vector}, 8'h00);
    nv_done_irq_enable = 1'b1;
    irq_service = 1'b1;
    step();
    irq_service = 1'b0;
    step();
    chk("svc", {mf_irq_flag, nv_done_irq_flag}, 8'h01);
    done_flag_clr = 1'b1;
    step();
    done_flag_clr = 1'b0;
    step();
    chk("done_clr", {7'h0, nv_done_irq_flag}, 8'h00);
    $display("test program done");
    ld(6'h2A, 8'h00);
    ind_wr(8'h02, 8'h03, 2);
    wait_low(NVW_BIT_FSTART);
    chk("fetch_ctrl", indirect_port1, 8'h02);
    chk("fetch_data", nv_byte_buffer, 8'hA5);
    ld(6'h2A, 8'h00);
    // Index moves on the same edge as the fetch start write; the started fetch keeps 2A
    idx_we = 1'b1;
    idx_wdata = 6'h15;
    ind_wr(8'h03, 8'h00, 1);
    idx_we = 1'b0;
    wait_low(NVW_BIT_FSTART);
    chk("idx_latched", nv_byte_buffer, 8'hA5);
    chk("idx_live", nv_cell_index, 8'h15);
    $display("test fetch done");
    ind_wr(8'h08, 8'h0C, 2);
    low_power = 1'b1;
    seen = 1'b0;
    for (int k = 0; k < 10 && seen == 1'b0; k++) begin
      step();
      seen = (op_failed === 1'b1);
    end
    low_power = 1'b0;
    chk("abort", {7'h0, seen}, 8'h01);
    chk("abort_ctrl", nv_control_reg, 8'h08);
    ticks(TICKS);
    repeat (10) step();
    chk("abort_done", {7'h0, nv_done_irq_flag}, 8'h00);
    $display("test abort done");
    summarize();
  end
endmodule : data_eeprom_write_controller_tb
`default_nettype wire
